// ===== design/mac_acc_map.vh
// constants for the multiply-accumulate datapath
`ifndef MAC_ACC_MAP_VH
`define MAC_ACC_MAP_VH
`define MAC_LEN_BYTES 3'h4
`define MAC_FMT_RR 8'hA3
`define MAC_FMT_RI 8'h83
`define MAC_FMT_II 8'h93
`define MAC_OP_ACC_RND 8'hD1
`define MAC_OP_ACC 8'hD0
`define MAC_OP_NEG 8'hE0
`define MAC_OP_MOVE_RND 8'hD9
`define MAC_OP_MOVE 8'hD8
`define MAC_OP_NEG_MOVE 8'hE8
`define MAC_RND_CONST 40'h0000008000
`define MAC_SAT_MAX 40'h007FFFFFFF
`define MAC_SAT_MIN 40'hFF80000000
`define MAC_ACC_RESET 40'h0000000000
`endif

// ===== design/mac_acc_decode.v
// decodes the instruction bytes of the accumulate family
`timescale 1ns/1ps
`include "mac_acc_map.vh"
module mac_acc_decode
(
  input wire [7:0] i_byte0,
  input wire [7:0] i_byte2,
  output reg o_valid,
  output reg o_sub,
  output reg o_rnd,
  output reg o_move
);
  reg fmt_ok;
  always @*
  begin
    fmt_ok = (i_byte0 == `MAC_FMT_RR) || (i_byte0 == `MAC_FMT_RI) || (i_byte0 == `MAC_FMT_II);
    o_valid = 1'b0;
    o_sub = 1'b0;
    o_rnd = 1'b0;
    o_move = 1'b0;
    case (i_byte2)
      `MAC_OP_ACC_RND:
      begin
        o_valid = fmt_ok;
        o_rnd = 1'b1;
      end
      `MAC_OP_ACC:
      begin
        o_valid = fmt_ok;
      end
      `MAC_OP_NEG:
      begin
        o_valid = fmt_ok;
        o_sub = 1'b1;
      end
      `MAC_OP_MOVE_RND:
      begin
        o_valid = (i_byte0 == `MAC_FMT_II);
        o_rnd = 1'b1;
        o_move = 1'b1;
      end
      `MAC_OP_MOVE:
      begin
        o_valid = (i_byte0 == `MAC_FMT_II);
        o_move = 1'b1;
      end
      `MAC_OP_NEG_MOVE:
      begin
        o_valid = (i_byte0 == `MAC_FMT_II);
        o_sub = 1'b1;
        o_move = 1'b1;
      end
      default:
      begin
        o_valid = 1'b0;
      end
    endcase
  end
endmodule

// ===== design/mac_acc_dual_port_ram.v
// small dual-port memory with registered read data
`timescale 1ns/1ps
module mac_acc_dual_port_ram
#(
  parameter AW = 6,
  parameter DW = 16
)
(
  input wire i_core_clk,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge i_core_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule

// ===== design/mac_acc_datapath.v
// multiply-accumulate datapath with flags and move copy
`timescale 1ns/1ps
`include "mac_acc_map.vh"
module mac_acc_datapath
#(
  parameter AW = 6
)
(
  input wire i_core_clk,
  input wire i_arst_n,
  input wire i_start,
  input wire [7:0] i_byte0,
  input wire [7:0] i_byte2,
  input wire signed [15:0] i_op1,
  input wire signed [15:0] i_op2,
  input wire i_product_shift_ctl,
  input wire i_sat_enable,
  input wire [AW-1:0] i_index_pointer,
  input wire [AW-1:0] i_index_pointer_next,
  input wire [AW-1:0] i_mem_raddr,
  input wire i_clear_sticky,
  output reg [39:0] o_acc,
  output reg o_overflow_flag,
  output reg o_sticky_saturate_flag,
  output reg o_extension_used_flag,
  output reg o_sticky_overflow_flag,
  output reg o_carry_flag,
  output reg o_zero_flag,
  output reg o_negative_flag,
  output reg o_illegal,
  output reg o_done,
  output reg [15:0] o_mem_rdata
);
  reg rst_s1;
  reg rst_n;
  wire dec_valid;
  wire dec_sub;
  wire dec_rnd;
  wire dec_move;
  reg [31:0] product;
  reg [39:0] prod_ext;
  reg [39:0] prep;
  reg [40:0] sum_a;
  reg [40:0] sum_b;
  reg [39:0] result;
  reg ovf;
  reg carry;
  reg rnd_ovf;
  reg sat_hi;
  reg sat_lo;
  reg [39:0] sat_result;
  reg exec;
  reg ovf_main;
  reg clamp;
  reg [39:0] next_acc;
  reg next_done;
  reg next_illegal;
  reg next_ovf_flag;
  reg next_sticky_ovf;
  reg next_sticky_sat;
  reg next_ext;
  reg next_carry;
  reg next_zero;
  reg next_neg;
  reg move_pend;
  reg [AW-1:0] move_dst;
  wire [15:0] ram_q;
  reg [AW-1:0] ram_raddr;

  // reset release through two stages
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // variant comes from decoder with operands in the same cycle
  mac_acc_decode u_dec
  (
    .i_byte0(i_byte0),
    .i_byte2(i_byte2),
    .o_valid(dec_valid),
    .o_sub(dec_sub),
    .o_rnd(dec_rnd),
    .o_move(dec_move)
  );

  // product preparation
  always @*
  begin
    product = i_op1 * i_op2;
    prod_ext = {{8{product[31]}}, product};
    if (i_product_shift_ctl)
    begin
      prep = {prod_ext[38:0], 1'b0};
    end
    else
    begin
      prep = prod_ext;
    end
  end

  // add or subtract the prepared product
  always @*
  begin
    if (dec_sub)
    begin
      sum_a = {1'b0, o_acc} - {1'b0, prep};
      ovf_main = (o_acc[39] != prep[39]) && (sum_a[39] != o_acc[39]);
    end
    else
    begin
      sum_a = {1'b0, o_acc} + {1'b0, prep};
      ovf_main = (o_acc[39] == prep[39]) && (sum_a[39] != o_acc[39]);
    end
  end

  // rounding step
  always @*
  begin
    sum_b = {1'b0, sum_a[39:0]} + {1'b0, `MAC_RND_CONST};
    if (dec_rnd)
    begin
      result = {sum_b[39:16], 16'h0000};
      rnd_ovf = !sum_a[39] && sum_b[39];
      carry = sum_a[40] | sum_b[40];
    end
    else
    begin
      result = sum_a[39:0];
      rnd_ovf = 1'b0;
      carry = sum_a[40];
    end
    ovf = ovf_main | rnd_ovf;
  end

  // clamp to the 32-bit signed range
  always @*
  begin
    sat_hi = 1'b0;
    sat_lo = 1'b0;
    if (i_sat_enable)
    begin
      if (ovf_main)
      begin
        sat_hi = !o_acc[39];
        sat_lo = o_acc[39];
      end
      else if (rnd_ovf)
      begin
        sat_hi = 1'b1;
      end
      else if (!result[39] && (result[39:31] != 9'h000))
      begin
        sat_hi = 1'b1;
      end
      else if (result[39] && (result[39:31] != 9'h1FF))
      begin
        sat_lo = 1'b1;
      end
    end
    clamp = sat_hi | sat_lo;
    if (sat_hi)
    begin
      sat_result = `MAC_SAT_MAX;
    end
    else if (sat_lo)
    begin
      sat_result = `MAC_SAT_MIN;
    end
    else
    begin
      sat_result = result;
    end
    if (dec_rnd && clamp)
    begin
      sat_result = {sat_result[39:16], 16'h0000};
    end
  end

  // next values of accumulator and flags, a set beats a clear
  always @*
  begin
    exec = i_start && dec_valid;
    next_done = exec;
    next_illegal = i_start && !dec_valid;
    next_acc = o_acc;
    next_ovf_flag = o_overflow_flag;
    next_sticky_ovf = o_sticky_overflow_flag;
    next_sticky_sat = o_sticky_saturate_flag;
    next_ext = o_extension_used_flag;
    next_carry = o_carry_flag;
    next_zero = o_zero_flag;
    next_neg = o_negative_flag;
    if (i_clear_sticky)
    begin
      next_sticky_ovf = 1'b0;
      next_sticky_sat = 1'b0;
    end
    if (exec)
    begin
      next_acc = sat_result;
      next_ovf_flag = ovf;
      if (ovf)
      begin
        next_sticky_ovf = 1'b1;
      end
      if (clamp)
      begin
        next_sticky_sat = 1'b1;
      end
      next_ext = (sat_result[39:31] != 9'h000) && (sat_result[39:31] != 9'h1FF);
      next_carry = carry;
      next_zero = (sat_result == 40'h0000000000);
      next_neg = sat_result[39];
    end
  end

  // outcome pulses
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_illegal <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= next_done;
      o_illegal <= next_illegal;
    end
  end

  // accumulator and flags
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_acc <= `MAC_ACC_RESET;
      o_overflow_flag <= 1'b0;
      o_sticky_saturate_flag <= 1'b0;
      o_extension_used_flag <= 1'b0;
      o_sticky_overflow_flag <= 1'b0;
      o_carry_flag <= 1'b0;
      o_zero_flag <= 1'b0;
      o_negative_flag <= 1'b0;
    end
    else
    begin
      o_acc <= next_acc;
      o_overflow_flag <= next_ovf_flag;
      o_sticky_saturate_flag <= next_sticky_sat;
      o_extension_used_flag <= next_ext;
      o_sticky_overflow_flag <= next_sticky_ovf;
      o_carry_flag <= next_carry;
      o_zero_flag <= next_zero;
      o_negative_flag <= next_neg;
    end
  end

  // move copy: read at index pointer, write at updated pointer
  always @*
  begin
    if (exec && dec_move)
    begin
      ram_raddr = i_index_pointer;
    end
    else
    begin
      ram_raddr = i_mem_raddr;
    end
  end

  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      move_pend <= 1'b0;
      move_dst <= {AW{1'b0}};
    end
    else
    begin
      move_pend <= i_start && dec_valid && dec_move;
      move_dst <= i_index_pointer_next;
    end
  end

  mac_acc_dual_port_ram #(.AW(AW), .DW(16)) u_ram
  (
    .i_core_clk(i_core_clk),
    .i_raddr(ram_raddr),
    .o_rdata(ram_q),
    .i_we(move_pend),
    .i_waddr(move_dst),
    .i_wdata(ram_q)
  );

  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_mem_rdata <= 16'h0000;
    end
    else
    begin
      o_mem_rdata <= ram_q;
    end
  end
endmodule

// ===== sim/mac_acc_checker_sva.sv
// assertion checker for the accumulate datapath
`timescale 1ns/1ps
`include "mac_acc_map.vh"
module mac_acc_checker
(
  input wire i_core_clk,
  input wire i_arst_n,
  input wire i_start,
  input wire [7:0] i_byte2,
  input wire [39:0] o_acc,
  input wire o_overflow_flag,
  input wire o_sticky_saturate_flag,
  input wire o_extension_used_flag,
  input wire o_sticky_overflow_flag,
  input wire o_zero_flag,
  input wire o_negative_flag,
  input wire o_illegal,
  input wire o_done
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  a_one_outcome: assert property (i_start |=> o_done ^ o_illegal) else $error("no single outcome");
  a_refused_holds: assert property (o_illegal |-> $stable(o_acc)) else $error("acc moved on refusal");
  a_idle_holds: assert property (!$past(i_start) |-> $stable(o_acc)) else $error("acc moved idle");
  a_zero_match: assert property (o_done |-> o_zero_flag == (o_acc == 40'h0)) else $error("zero flag");
  a_sign_match: assert property (o_done |-> o_negative_flag == o_acc[39]) else $error("sign flag");
  a_ext_match: assert property (o_done |-> o_extension_used_flag ==
    (o_acc[39:31] != 9'h0 && o_acc[39:31] != 9'h1FF)) else $error("extension flag");
  a_round_low: assert property (o_done && ($past(i_byte2) == `MAC_OP_ACC_RND ||
    $past(i_byte2) == `MAC_OP_MOVE_RND) |-> o_acc[15:0] == 16'h0) else $error("low half kept");
  a_sticky_ovf: assert property (o_done && o_overflow_flag |-> o_sticky_overflow_flag) else $error("sticky");
  c_done: cover property (o_done);
  c_refused: cover property (o_illegal);
  c_clamped: cover property ($rose(o_sticky_saturate_flag));
endmodule
bind mac_acc_datapath mac_acc_checker u_chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_start(i_start),
  .i_byte2(i_byte2), .o_acc(o_acc), .o_overflow_flag(o_overflow_flag), .o_done(o_done),
  .o_sticky_saturate_flag(o_sticky_saturate_flag), .o_extension_used_flag(o_extension_used_flag),
  .o_sticky_overflow_flag(o_sticky_overflow_flag), .o_zero_flag(o_zero_flag),
  .o_negative_flag(o_negative_flag), .o_illegal(o_illegal));

// ===== sim/mac_acc_fetch.sv
// operand fetch model: drives instructions, predicts results
`timescale 1ns/1ps
`include "mac_acc_map.vh"
module mac_acc_fetch
(
  input wire i_core_clk
);
  logic start = '0, sh = '0, sat = '0, clr = '0, v, sub, rnd, o, c, s;
  logic m_ov = '0, m_c = '0, m_so = '0, m_ss = '0;
  logic [40:0] w;
  logic [7:0] b0 = '0, b2 = '0;
  logic signed [15:0] a = '0, b = '0;
  logic signed [31:0] prod;
  logic [5:0] ip = '0, ipn = '0, ra = '0;
  logic [7:0] fmt [4] = '{`MAC_FMT_RR, `MAC_FMT_RI, `MAC_FMT_II, 8'h5A};
  logic [7:0] ops [7] = '{`MAC_OP_ACC, `MAC_OP_ACC_RND, `MAC_OP_NEG, `MAC_OP_MOVE, `MAC_OP_MOVE_RND,
    `MAC_OP_NEG_MOVE, 8'h22};
  logic [39:0] m_acc = '0, p, r;
  logic [47:0] q [$];
  task issue(input logic go);
    begin
      @(posedge i_core_clk);
      start <= go && $urandom % 5 != 0;
      b0 <= fmt[$urandom % 4];
      b2 <= ops[$urandom % 7];
      a <= 16'($urandom);
      b <= 16'($urandom);
      sh <= 1'($urandom);
      sat <= 1'($urandom);
      clr <= $urandom % 9 == 0;
      ip <= 6'($urandom);
      ipn <= 6'($urandom);
      ra <= 6'($urandom);
      #1;
      if (clr)
      begin
        m_so = 1'b0;
        m_ss = 1'b0;
      end
      if (start)
      begin
        v = (b0 == `MAC_FMT_RR || b0 == `MAC_FMT_RI || b0 == `MAC_FMT_II) && (b2 == `MAC_OP_ACC ||
          b2 == `MAC_OP_ACC_RND || b2 == `MAC_OP_NEG || (b0 == `MAC_FMT_II && (b2 == `MAC_OP_MOVE ||
          b2 == `MAC_OP_MOVE_RND || b2 == `MAC_OP_NEG_MOVE)));
        sub = b2 == `MAC_OP_NEG || b2 == `MAC_OP_NEG_MOVE;
        rnd = b2 == `MAC_OP_ACC_RND || b2 == `MAC_OP_MOVE_RND;
        prod = a * b;
        p = {{8{prod[31]}}, prod} << sh;
        w = sub ? {1'b0, m_acc} - {1'b0, p} : {1'b0, m_acc} + {1'b0, p};
        o = ((m_acc[39] ^ sub) == p[39]) && (w[39] != m_acc[39]);
        c = w[40];
        r = w[39:0];
        if (rnd)
        begin
          w = {1'b0, r} + {1'b0, `MAC_RND_CONST};
          o = o | (!r[39] && w[39]);
          c = c | w[40];
          r = w[39:0];
        end
        s = sat && ($signed(r) > $signed(`MAC_SAT_MAX) || $signed(r) < $signed(`MAC_SAT_MIN));
        if (sat && $signed(r) > $signed(`MAC_SAT_MAX))
          r = `MAC_SAT_MAX;
        if (sat && $signed(r) < $signed(`MAC_SAT_MIN))
          r = `MAC_SAT_MIN;
        if (rnd)
          r[15:0] = 16'h0000;
        if (v)
        begin
          m_acc = r;
          m_ov = o;
          m_c = c;
          m_so = m_so | o;
          m_ss = m_ss | s;
        end
        q.push_back({!v, m_acc, m_acc == 40'h0, m_acc[39], m_acc[39:31] != 9'h0 && m_acc[39:31] != 9'h1FF, m_ov, m_c,
          m_so, m_ss});
      end
    end
  endtask
endmodule

// ===== sim/mac_accumulate_datapath_bench.sv
// self-checking bench for the accumulate datapath
`timescale 1ns/1ps
module mac_accumulate_datapath_bench;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [47:0] e;
  int err_count = 0, total_checks = 0;
  wire [39:0] acc;
  wire zf, nf, ext, ill, done, ovf, cf, so, ss;
  mac_acc_fetch u_fetch (.i_core_clk(clk));
  mac_acc_datapath uut (.i_core_clk(clk), .i_arst_n(rst_n), .i_start(u_fetch.start), .i_byte0(u_fetch.b0),
    .i_byte2(u_fetch.b2), .i_op1(u_fetch.a), .i_op2(u_fetch.b), .i_product_shift_ctl(u_fetch.sh),
    .i_sat_enable(u_fetch.sat), .i_index_pointer(u_fetch.ip), .i_index_pointer_next(u_fetch.ipn),
    .i_mem_raddr(u_fetch.ra), .i_clear_sticky(u_fetch.clr), .o_acc(acc), .o_overflow_flag(ovf),
    .o_sticky_saturate_flag(ss), .o_extension_used_flag(ext), .o_sticky_overflow_flag(so), .o_carry_flag(cf),
    .o_zero_flag(zf), .o_negative_flag(nf), .o_illegal(ill), .o_done(done), .o_mem_rdata());
  always #10 clk = ~clk;
  task check_acc(input logic [40:0] exp, input logic [40:0] got);
    begin
      total_checks++;
      if (got !== exp)
      begin
        err_count++;
        $display("BAD acc exp %h got %h", exp, got);
      end
    end
  endtask
  task check_flags(input logic [6:0] exp, input logic [6:0] got);
    begin
      total_checks++;
      if (got !== exp)
      begin
        err_count++;
        $display("BAD flags exp %b got %b", exp, got);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (err_count == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(negedge clk)
    if (done || ill)
    begin
      e = u_fetch.q.pop_front();
      check_acc(e[47:7], {ill, acc});
      if (done)
        check_flags(e[6:0], {zf, nf, ext, ovf, cf, so, ss});
    end
  initial
  begin
    #30000;
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'hDB58));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (800)
      u_fetch.issue(1'b1);
    u_fetch.issue(1'b0);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule
